/* rtl/charger_defs.svh */
// constants for the charger power mode controller
`ifndef CHARGER_DEFS_SVH
`define CHARGER_DEFS_SVH
`define ADDR_W 8
`define DATA_W 8
`define CNT_W 26
`define MON_W 5
`define PCT_W 7
// register offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h01
`define REG_FAULT 8'h02
`define REG_MONITOR 8'h03
// control bit positions and reset value
`define CTRL_SHIP 0
`define CTRL_HIZ 1
`define CTRL_LPA 2
`define CTRL_CHG 3
`define CTRL_LSW 4
`define CTRL_MON 5
`define CTRL_RESET 8'h08
// fault bit positions
`define FAULT_SLEEP 0
`define FAULT_BATUV 1
// clock rate and times
`define CLK_FREQ_MHZ 20
`define QUIET_TIME_US 1000
`define INT_PULSE_US 128
`define MON_WAIT_US 2000
`define HOST_READY_US 5000
`define WAKE_HOLD_US 500000
`define RESET_HOLD_US 1000000
`define SC_DEGLITCH_US 250
`define SC_RECOVERY_US 250000
// monitor scale: percent of charge voltage target
`define MON_PCT_LOW 7'h3c
`define MON_PCT_STEP 7'h02
`define MON_LEVEL_MAX 5'h14
`endif

/* rtl/charger_pkg.sv */
// types shared by the charger power mode controller
package charger_pkg;
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b000,
    ST_SHIP_QUIET = 3'b001,
    ST_SHIP = 3'b010,
    ST_WAKING = 3'b011,
    ST_HIZ_PREP = 3'b100,
    ST_HIZ = 3'b101
  } mode_e;
  // comparator results and pins, one bit each
  typedef struct packed {
    logic vin_valid;
    logic vin_above_sleep;
    logic push_button_n;
    logic charge_disable_n;
    logic load_switch_control_pin;
    logic short_circuit;
    logic bat_below_input_undervoltage_threshold;
    logic bat_above_input_undervoltage_threshold_hyst;
    logic bat_above_min_input_undervoltage_threshold;
    logic sys_in_regulation;
  } pins_s;
endpackage : charger_pkg

/* rtl/battery_monitor_sampler.sv */
// battery voltage monitor sample and latch
`timescale 1ns/1ns
`include "charger_defs.svh"
module battery_monitor_sampler #(
  parameter int unsigned WAIT_CYC = `MON_WAIT_US * `CLK_FREQ_MHZ
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [`PCT_W-1:0] i_ratio_pct,
  output logic o_busy,
  output logic o_done,
  output logic [`MON_W-1:0] o_level
);
  logic [`PCT_W-1:0] pct_meta_q, pct_q;
  logic [`CNT_W-1:0] cnt_q, cnt_d;
  logic busy_d, done_d;
  logic [`MON_W-1:0] level_d;

  // percent to 2% steps from 60% up to 100%
  function automatic logic [`MON_W-1:0] to_level(input logic [`PCT_W-1:0] pct);
    logic [`PCT_W-1:0] diff;
    diff = pct - `MON_PCT_LOW;
    if (pct < `MON_PCT_LOW) return '0;
    if ((diff / `MON_PCT_STEP) > `PCT_W'(`MON_LEVEL_MAX)) return `MON_LEVEL_MAX;
    return `MON_W'(diff / `MON_PCT_STEP);
  endfunction : to_level

  // sample waits out the settle time, then latches
  always_comb begin
    busy_d = o_busy;
    done_d = 1'b0;
    cnt_d = cnt_q;
    level_d = o_level;
    if (i_start && !o_busy) begin
      busy_d = 1'b1;
      cnt_d = '0;
    end else if (o_busy) begin
      if (cnt_q >= `CNT_W'(WAIT_CYC - 1)) begin
        busy_d = 1'b0;
        done_d = 1'b1;
        level_d = to_level(pct_q);
      end else begin
        cnt_d = cnt_q + `CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pct_meta_q <= '0;
      pct_q <= '0;
      cnt_q <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_level <= '0;
    end else begin
      pct_meta_q <= i_ratio_pct;
      pct_q <= pct_meta_q;
      cnt_q <= cnt_d;
      o_busy <= busy_d;
      o_done <= done_d;
      o_level <= level_d;
    end
  end
endmodule : battery_monitor_sampler

/* rtl/charger_power_mode_controller.sv */
// power mode sequencer of the battery charge manager
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "charger_defs.svh"
module charger_power_mode_controller #(
  parameter int unsigned QUIET_CYC = `QUIET_TIME_US * `CLK_FREQ_MHZ,
  parameter int unsigned READY_CYC = `HOST_READY_US * `CLK_FREQ_MHZ,
  parameter int unsigned WAKE_CYC = `WAKE_HOLD_US * `CLK_FREQ_MHZ,
  parameter int unsigned RESET_CYC = `RESET_HOLD_US * `CLK_FREQ_MHZ,
  parameter int unsigned SC_REC_CYC = `SC_RECOVERY_US * `CLK_FREQ_MHZ,
  parameter int unsigned MON_CYC = `MON_WAIT_US * `CLK_FREQ_MHZ
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire charger_pkg::pins_s i_pins,
  input wire logic [`PCT_W-1:0] i_battery_ratio_pct,
  input wire logic [`ADDR_W-1:0] i_addr,
  input wire logic [`DATA_W-1:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [`DATA_W-1:0] o_rd_data,
  output logic o_battery_switch_en,
  output logic o_supplement_en,
  output logic o_charge_en,
  output logic o_charge_cycle_start,
  output logic o_device_latched_off,
  output logic o_mid_power_pulldown,
  output logic o_load_switch_en,
  output logic o_interrupt_pulse,
  output logic o_serial_enable,
  output logic o_host_if_ready
);
  import charger_pkg::*;

  localparam int unsigned SC_DGL_CYC = `SC_DEGLITCH_US * `CLK_FREQ_MHZ;
  localparam int unsigned INT_CYC = `INT_PULSE_US * `CLK_FREQ_MHZ;

  pins_s meta_q, pin_q, prev_q;
  logic [2:0] prime_q;
  mode_e st_q, st_d;
  logic [`DATA_W-1:0] ctrl_q, ctrl_d, fault_q, fault_d, rd_d;
  logic [`CNT_W-1:0] quiet_q, quiet_d, pb_q, pb_d, adp_q, adp_d;
  logic [`CNT_W-1:0] sc_q, sc_d, int_q, int_d, rdy_q, rdy_d;
  logic pend_q, pend_d, sc_off_q, sc_off_d, bat_ok_q, bat_ok_d;
  logic lock_q, lock_d, mon_start_q, mon_start_d;
  logic batsw_d, supp_d, chg_d, start_d, off_d, pd_d, ls_d, int_en_d, ser_d, rdy_en_d;
  logic mon_busy, mon_done;
  logic [`MON_W-1:0] mon_level;
  logic ship_cond, hiz_cause, sleep_fall, sleep_rise, cd_edge, wr_ctrl, rd_fault, normal;

  // counter helpers
  function automatic logic [`CNT_W-1:0] inc(input logic [`CNT_W-1:0] c);
    return (&c) ? c : c + `CNT_W'(1);
  endfunction : inc

  function automatic logic hit(input logic [`CNT_W-1:0] c, input int unsigned lim);
    return c >= `CNT_W'(lim - 1);
  endfunction : hit

  battery_monitor_sampler #(
    .WAIT_CYC(MON_CYC)
  ) u_monitor (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_start(mon_start_q),
    .i_ratio_pct(i_battery_ratio_pct),
    .o_busy(mon_busy),
    .o_done(mon_done),
    .o_level(mon_level)
  );

  // pin events, held off until prev stage holds a real sample after reset
  assign sleep_fall = prime_q[2] && prev_q.vin_above_sleep && !pin_q.vin_above_sleep;
  assign sleep_rise = prime_q[2] && !prev_q.vin_above_sleep && pin_q.vin_above_sleep;
  assign cd_edge = prime_q[2] && (prev_q.charge_disable_n != pin_q.charge_disable_n);
  assign wr_ctrl = i_wr_en && (i_addr == `REG_CTRL);
  assign rd_fault = i_rd_en && (i_addr == `REG_FAULT);
  // ship entry conditions, all watched for the quiet interval
  assign ship_cond = (ctrl_q[`CTRL_SHIP] || pend_q) && !pin_q.vin_valid
    && pin_q.charge_disable_n && pin_q.push_button_n;
  // hi-z wanted with battery only
  assign hiz_cause = !pin_q.vin_valid && bat_ok_q
    && (!pin_q.charge_disable_n || ctrl_q[`CTRL_HIZ]);
  assign normal = (st_q == ST_ACTIVE) || (st_q == ST_SHIP_QUIET)
    || (st_q == ST_HIZ_PREP) || (st_q == ST_HIZ);

  // mode sequencing
  always_comb begin
    st_d = st_q;
    quiet_d = quiet_q;
    pend_d = pend_q;
    adp_d = '0;
    lock_d = lock_q;
    mon_start_d = 1'b0;
    ctrl_d = ctrl_q;
    // button low time, kept until the first high cycle is seen
    pb_d = pin_q.push_button_n ? '0 : inc(pb_q);
    if (wr_ctrl) begin
      ctrl_d = i_wr_data;
      if (!i_wr_data[`CTRL_SHIP] && pin_q.vin_valid) begin
        pend_d = 1'b0;
      end
      mon_start_d = i_wr_data[`CTRL_MON];
    end
    ctrl_d[`CTRL_MON] = 1'b0;
    // long press arms entry
    if (!pin_q.push_button_n && !ctrl_q[`CTRL_LPA] && hit(pb_q, RESET_CYC)
        && !hit(pb_q, RESET_CYC + 1)) begin
      pend_d = 1'b1;
    end
    // adapter during long press: keep armed unless released or held too long
    if (pend_q && pin_q.vin_valid && !prev_q.vin_valid && pin_q.push_button_n) begin
      pend_d = 1'b0;
    end else if (pend_q && pin_q.vin_valid && !pin_q.push_button_n) begin
      adp_d = inc(adp_q);
      if (hit(adp_q, WAKE_CYC)) begin
        pend_d = 1'b0;
      end
    end
    if (cd_edge) begin
      lock_d = 1'b0;
    end
    unique case (st_q)
      ST_ACTIVE: begin
        quiet_d = '0;
        if (ship_cond) begin
          st_d = ST_SHIP_QUIET;
        end else if (hiz_cause) begin
          st_d = ST_HIZ_PREP;
          mon_start_d = 1'b1;
        end
      end
      ST_SHIP_QUIET: begin
        if (!ship_cond) begin
          st_d = ST_ACTIVE;
        end else if (hit(quiet_q, QUIET_CYC)) begin
          st_d = ST_SHIP;
          pend_d = 1'b0;
          ctrl_d[`CTRL_SHIP] = 1'b0;
        end else begin
          quiet_d = inc(quiet_q);
        end
      end
      ST_SHIP: begin
        if (pin_q.vin_valid && pin_q.vin_above_sleep) begin
          st_d = ST_ACTIVE;
        end else if (!pin_q.push_button_n) begin
          st_d = ST_WAKING;
        end
      end
      ST_WAKING: begin
        if (pin_q.vin_valid && pin_q.vin_above_sleep) begin
          st_d = ST_ACTIVE;
        end else if (pin_q.push_button_n) begin
          st_d = hit(pb_q, WAKE_CYC) ? ST_ACTIVE : ST_SHIP;
        end
      end
      ST_HIZ_PREP: begin
        if (!hiz_cause) begin
          st_d = ST_ACTIVE;
        end else if (mon_done) begin
          st_d = ST_HIZ;
          lock_d = ctrl_q[`CTRL_HIZ];
        end
      end
      ST_HIZ: begin
        if (pin_q.vin_valid || cd_edge) begin
          st_d = ST_ACTIVE;
          ctrl_d[`CTRL_HIZ] = 1'b0;
        end
      end
      default: begin
        st_d = ST_ACTIVE;
      end
    endcase
  end

  // power switches, protection and host readiness
  always_comb begin
    bat_ok_d = bat_ok_q;
    if (pin_q.bat_below_input_undervoltage_threshold) begin
      bat_ok_d = 1'b0;
    end else if (pin_q.bat_above_input_undervoltage_threshold_hyst) begin
      bat_ok_d = 1'b1;
    end
    sc_off_d = sc_off_q;
    sc_d = '0;
    if (sc_off_q) begin
      sc_d = inc(sc_q);
      if (hit(sc_q, SC_REC_CYC)) begin
        sc_off_d = 1'b0;
        sc_d = '0;
      end
    end else if (pin_q.short_circuit && o_battery_switch_en) begin
      sc_d = inc(sc_q);
      if (hit(sc_q, SC_DGL_CYC)) begin
        sc_off_d = 1'b1;
        sc_d = '0;
      end
    end
    off_d = (st_q == ST_SHIP) || (st_q == ST_WAKING);
    pd_d = st_q == ST_SHIP;
    batsw_d = normal && bat_ok_q && !sc_off_q
      && (!pin_q.vin_valid || !pin_q.vin_above_sleep
      || pin_q.bat_above_min_input_undervoltage_threshold);
    supp_d = normal && pin_q.vin_valid && bat_ok_q && !sc_off_q
      && pin_q.bat_above_min_input_undervoltage_threshold;
    chg_d = (st_q == ST_ACTIVE) && pin_q.vin_valid && pin_q.vin_above_sleep
      && !pin_q.charge_disable_n && ctrl_q[`CTRL_CHG];
    start_d = sleep_rise && pin_q.vin_valid;
    ls_d = !off_d && (ctrl_q[`CTRL_LSW] || pin_q.load_switch_control_pin);
    rdy_d = pin_q.sys_in_regulation ? inc(rdy_q) : '0;
    rdy_en_d = pin_q.sys_in_regulation && hit(rdy_q, READY_CYC);
    ser_d = rdy_en_d && !lock_q && !off_d;
  end

  // fault flags and interrupt pulse
  always_comb begin
    fault_d = fault_q;
    if (rd_fault) begin
      if (pin_q.vin_above_sleep) begin
        fault_d[`FAULT_SLEEP] = 1'b0;
      end
      if (bat_ok_q) begin
        fault_d[`FAULT_BATUV] = 1'b0;
      end
    end
    // set wins over a read in the same cycle
    if (sleep_fall) begin
      fault_d[`FAULT_SLEEP] = 1'b1;
    end
    if (bat_ok_q && !bat_ok_d) begin
      fault_d[`FAULT_BATUV] = 1'b1;
    end
    int_d = '0;
    int_en_d = 1'b0;
    if (o_interrupt_pulse) begin
      int_d = inc(int_q);
      int_en_d = !hit(int_q, INT_CYC);
    end else if (sleep_fall) begin
      int_en_d = 1'b1;
    end
  end

  // register read data, one cycle after the strobe
  always_comb begin
    rd_d = '0;
    if (i_rd_en) begin
      unique case (i_addr)
        `REG_CTRL: rd_d = ctrl_q;
        `REG_STATUS: rd_d = {mon_busy, o_host_if_ready, bat_ok_q, sc_off_q, pend_q, st_q};
        `REG_FAULT: rd_d = fault_q;
        `REG_MONITOR: rd_d = `DATA_W'(mon_level);
        default: rd_d = '0;
      endcase
    end
  end

  // input synchronisers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      pin_q <= '0;
      prev_q <= '0;
      prime_q <= '0;
    end else begin
      meta_q <= i_pins;
      pin_q <= meta_q;
      prev_q <= pin_q;
      prime_q <= {prime_q[1:0], 1'b1};
    end
  end

  // state registers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= ST_ACTIVE;
      ctrl_q <= `CTRL_RESET;
      fault_q <= '0;
      quiet_q <= '0;
      pb_q <= '0;
      adp_q <= '0;
      sc_q <= '0;
      int_q <= '0;
      rdy_q <= '0;
      pend_q <= 1'b0;
      sc_off_q <= 1'b0;
      bat_ok_q <= 1'b0;
      lock_q <= 1'b0;
      mon_start_q <= 1'b0;
      o_rd_data <= '0;
      o_battery_switch_en <= 1'b0;
      o_supplement_en <= 1'b0;
      o_charge_en <= 1'b0;
      o_charge_cycle_start <= 1'b0;
      o_device_latched_off <= 1'b0;
      o_mid_power_pulldown <= 1'b0;
      o_load_switch_en <= 1'b0;
      o_interrupt_pulse <= 1'b0;
      o_serial_enable <= 1'b0;
      o_host_if_ready <= 1'b0;
    end else begin
      st_q <= st_d;
      ctrl_q <= ctrl_d;
      fault_q <= fault_d;
      quiet_q <= quiet_d;
      pb_q <= pb_d;
      adp_q <= adp_d;
      sc_q <= sc_d;
      int_q <= int_d;
      rdy_q <= rdy_d;
      pend_q <= pend_d;
      sc_off_q <= sc_off_d;
      bat_ok_q <= bat_ok_d;
      lock_q <= lock_d;
      mon_start_q <= mon_start_d;
      o_rd_data <= rd_d;
      o_battery_switch_en <= batsw_d;
      o_supplement_en <= supp_d;
      o_charge_en <= chg_d;
      o_charge_cycle_start <= start_d;
      o_device_latched_off <= off_d;
      o_mid_power_pulldown <= pd_d;
      o_load_switch_en <= ls_d;
      o_interrupt_pulse <= int_en_d;
      o_serial_enable <= ser_d;
      o_host_if_ready <= rdy_en_d;
    end
  end
endmodule : charger_power_mode_controller

/* tb/host_button_model.sv */
// adapter, push-button and host pin levels at the controller
`timescale 1ns/1ns
module host_button_model (
  input wire logic i_adapter,
  input wire logic i_press,
  input wire logic i_cd_drive,
  input wire logic i_cd_level,
  input wire logic i_short,
  input wire logic i_bat_low,
  output charger_pkg::pins_s o_pins
);
  import charger_pkg::*;
  // adapter moves both input comparators; battery undervoltage follows i_bat_low
  always_comb begin
    o_pins = '0;
    o_pins.vin_valid = i_adapter;
    o_pins.vin_above_sleep = i_adapter;
    o_pins.push_button_n = !i_press;
    o_pins.charge_disable_n = i_cd_drive & i_cd_level;
    o_pins.short_circuit = i_short;
    o_pins.bat_below_input_undervoltage_threshold = i_bat_low;
    o_pins.bat_above_input_undervoltage_threshold_hyst = !i_bat_low;
    o_pins.bat_above_min_input_undervoltage_threshold = 1'b1;
    o_pins.sys_in_regulation = 1'b1;
  end
endmodule : host_button_model

/* tb/charger_power_mode_controller_chk.sv */
// port assertions for the power mode controller
`timescale 1ns/1ns
`include "charger_defs.svh"
module charger_power_mode_controller_chk #(
  parameter int unsigned READY_CYC = 50
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire charger_pkg::pins_s i_pins,
  input wire logic [`ADDR_W-1:0] i_addr,
  input wire logic [`DATA_W-1:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [`DATA_W-1:0] o_rd_data,
  input wire logic o_battery_switch_en,
  input wire logic o_charge_cycle_start,
  input wire logic o_device_latched_off,
  input wire logic o_mid_power_pulldown,
  input wire logic o_interrupt_pulse,
  input wire logic o_serial_enable,
  input wire logic o_host_if_ready
);
  import charger_pkg::*;
  localparam int unsigned PULSE_CYC = `INT_PULSE_US * `CLK_FREQ_MHZ;
  logic [`CNT_W-1:0] irq_cnt_d, irq_cnt_q, reg_cnt_d, reg_cnt_q;
  // run lengths of the pulse and of regulation
  always_comb begin
    irq_cnt_d = o_interrupt_pulse ? irq_cnt_q + 1'b1 : '0;
    reg_cnt_d = i_pins.sys_in_regulation ? reg_cnt_q + 1'b1 : '0;
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_cnt_q <= '0;
      reg_cnt_q <= '0;
    end else begin
      irq_cnt_q <= irq_cnt_d;
      reg_cnt_q <= reg_cnt_d;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  a_irq_pulse_width: assert property (
    $fell(o_interrupt_pulse) |-> irq_cnt_q == PULSE_CYC) else $error("pulse width wrong");
  a_ship_no_input: assert property (
    $rose(o_device_latched_off) |-> !$past(i_pins.vin_valid, 4)) else $error("ship with input");
  a_latched_all_off: assert property (
    o_device_latched_off |-> !o_battery_switch_en && !o_serial_enable)
    else $error("latched off not off");
  a_pulldown_in_ship: assert property (
    o_mid_power_pulldown |-> o_device_latched_off) else $error("pulldown outside ship");
  a_ship_pulldown_on: assert property (
    $rose(o_device_latched_off) |-> o_mid_power_pulldown) else $error("no pulldown on entry");
  a_cycle_start_once: assert property (
    o_charge_cycle_start |=> !o_charge_cycle_start) else $error("cycle start too long");
  a_serial_needs_ready: assert property (
    o_serial_enable |-> o_host_if_ready) else $error("serial before ready");
  a_ready_after_run: assert property (
    $rose(o_host_if_ready) |-> reg_cnt_q >= READY_CYC) else $error("ready too early");
  a_rd_idle_zero: assert property (
    !$past(i_rd_en) |-> o_rd_data == '0) else $error("read data outside slot");
  a_rd_unmapped: assert property (
    i_rd_en && i_addr > `REG_MONITOR |=> o_rd_data == '0) else $error("unmapped read");
  a_ctrl_readback: assert property (
    i_wr_en && i_addr == `REG_CTRL ##2 i_rd_en && i_addr == `REG_CTRL
    |=> o_rd_data[4:2] == $past(i_wr_data[4:2], 3)) else $error("control readback");
endmodule : charger_power_mode_controller_chk
bind charger_power_mode_controller charger_power_mode_controller_chk #(
  .READY_CYC(READY_CYC)) u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_pins(i_pins),
  .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
  .o_rd_data(o_rd_data), .o_battery_switch_en(o_battery_switch_en),
  .o_charge_cycle_start(o_charge_cycle_start), .o_device_latched_off(o_device_latched_off),
  .o_mid_power_pulldown(o_mid_power_pulldown), .o_interrupt_pulse(o_interrupt_pulse),
  .o_serial_enable(o_serial_enable), .o_host_if_ready(o_host_if_ready));

/* tb/charger_power_mode_controller_tb.sv */
// register and pin sequences for the power mode controller
`timescale 1ns/1ns
`include "charger_defs.svh"
module charger_power_mode_controller_tb;
  import charger_pkg::*;
  localparam int unsigned QUIET = 20;
  localparam int unsigned MON = 30;
  logic i_sys_clk, i_rst, i_wr_en, i_rd_en, adapter, press, cd_drive, cd_level;
  logic [7:0] i_addr, i_wr_data, o_rd_data, v;
  logic [6:0] pct;
  logic [6:0] ptab [3] = '{7'h64, 7'h32, 7'h51};
  logic [7:0] mtab [3] = '{8'h14, 8'h00, 8'h0a};
  pins_s pins;
  logic bsw, sup, chg, cyc, latched, pdn, lsw, irq, ser, rdy, short, bat_low;
  int errors, checks_done, n;
  host_button_model far (.i_adapter(adapter), .i_press(press), .i_cd_drive(cd_drive),
    .i_cd_level(cd_level), .i_short(short), .i_bat_low(bat_low), .o_pins(pins));
  charger_power_mode_controller #(.QUIET_CYC(QUIET), .READY_CYC(50), .WAKE_CYC(30),
    .RESET_CYC(40), .SC_REC_CYC(25), .MON_CYC(MON)) dut (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .i_pins(pins), .i_battery_ratio_pct(pct), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
    .o_battery_switch_en(bsw), .o_supplement_en(sup), .o_charge_en(chg),
    .o_charge_cycle_start(cyc), .o_device_latched_off(latched), .o_mid_power_pulldown(pdn),
    .o_load_switch_en(lsw), .o_interrupt_pulse(irq), .o_serial_enable(ser),
    .o_host_if_ready(rdy));
  // free-running system clock
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  task automatic print_verdict;
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge i_sys_clk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_wr_en <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    tick(1);
    i_wr_en <= 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    i_rd_en <= 1'b1;
    i_addr <= a;
    tick(1);
    i_rd_en <= 1'b0;
    tick(1);
    v = o_rd_data;
  endtask : rd
  function automatic logic sig(input int s);
    case (s)
      0: return latched;
      1: return ser;
      2: return rdy;
      4: return bsw;
      default: return cyc;
    endcase
  endfunction : sig
  // bounded wait for an output level, count in n
  task automatic wt(input int s, input logic val, input int lim);
    n = 0;
    while (sig(s) !== val && n < lim) begin
      tick(1);
      n++;
    end
    if (sig(s) !== val) begin
      errors++;
      print_verdict();
    end
  endtask : wt
  // main sequence
  initial begin
    {i_rst, adapter, cd_drive, cd_level} = 4'hf;
    {i_wr_en, i_rd_en, press, short, bat_low, i_addr, i_wr_data, pct} = '0;
    tick(16);
    i_rst <= 1'b0;
    wt(2, 1'b1, 200);
    rd(`REG_CTRL); chk("ctrl", v, `CTRL_RESET);
    rd(`REG_FAULT); chk("fault", v, 8'h00);
    wr(8'h04, 8'hff);
    rd(8'h04); chk("unmapped", v, 8'h00);
    rd(`REG_CTRL); chk("ctrl", v, `CTRL_RESET);
    cd_drive <= 1'b0;
    tick(6); chk("charge on", 8'(chg), 8'h01);
    chk("supplement", 8'(sup), 8'h01);
    cd_drive <= 1'b1;
    tick(6); chk("charge off", 8'(chg), 8'h00);
    short <= 1'b1;
    wt(4, 1'b0, 5100);
    rd(`REG_STATUS); chk("short off", 8'(v[4]), 8'h01);
    short <= 1'b0;
    wt(4, 1'b1, 60);
    bat_low <= 1'b1;
    tick(6); chk("bat uv off", 8'(bsw), 8'h00);
    rd(`REG_FAULT); chk("fault", v, 8'h02);
    bat_low <= 1'b0;
    tick(6); chk("bat uv on", 8'(bsw), 8'h01);
    rd(`REG_FAULT); chk("fault", v, 8'h02);
    rd(`REG_FAULT); chk("fault", v, 8'h00);
    wr(`REG_CTRL, 8'h09);
    rd(`REG_CTRL); chk("pending", v, 8'h09);
    rd(`REG_STATUS); chk("no ship", v[2:0], 8'h00);
    adapter <= 1'b0;
    wt(0, 1'b1, 200);
    chk("quiet", 8'(n >= QUIET && n <= QUIET + 8), 8'h01);
    chk("irq", 8'(irq), 8'h01);
    chk("bat switch", 8'(bsw), 8'h00);
    chk("pulldown", 8'(pdn), 8'h01);
    rd(`REG_FAULT); chk("fault", v, 8'h01);
    rd(`REG_FAULT); chk("fault", v, 8'h01);
    press <= 1'b1;
    tick(10);
    press <= 1'b0;
    tick(8); chk("short press", 8'(latched), 8'h01);
    press <= 1'b1;
    tick(34);
    press <= 1'b0;
    wt(0, 1'b0, 20);
    rd(`REG_STATUS); chk("awake", v[2:0], 8'h00);
    press <= 1'b1;
    tick(50);
    press <= 1'b0;
    wt(0, 1'b1, 200);
    adapter <= 1'b1;
    wt(3, 1'b1, 12);
    tick(4); chk("exit", 8'(latched), 8'h00);
    rd(`REG_FAULT); chk("fault", v, 8'h01);
    rd(`REG_FAULT); chk("fault", v, 8'h00);
    wr(`REG_CTRL, 8'h09);
    wr(`REG_CTRL, 8'h08);
    adapter <= 1'b0;
    tick(QUIET * 3);
    rd(`REG_STATUS); chk("cancel", v[3:0], 8'h00);
    adapter <= 1'b1;
    tick(6);
    for (int i = 0; i < 3; i++) begin
      pct <= ptab[i];
      tick(4);
      wr(`REG_CTRL, 8'h20);
      tick(MON + 6);
      rd(`REG_MONITOR); chk("monitor", v, mtab[i]);
      wr(`REG_CTRL, 8'h08);
    end
    wr(`REG_CTRL, 8'h18);
    pct <= 7'h46;
    adapter <= 1'b0;
    cd_drive <= 1'b0;
    n = 0;
    do begin
      rd(`REG_STATUS);
      n++;
    end while (v[2:0] !== 3'h5 && n < 60);
    chk("hi-z", v[2:0], 8'h05);
    chk("load switch", 8'(lsw), 8'h01);
    chk("sys on bat", 8'(bsw), 8'h01);
    rd(`REG_MONITOR); chk("monitor", v, 8'h05);
    cd_drive <= 1'b1;
    tick(8);
    wr(`REG_CTRL, 8'h0a);
    wt(1, 1'b0, 100);
    cd_level <= 1'b0;
    tick(6);
    cd_level <= 1'b1;
    wt(1, 1'b1, 100);
    print_verdict();
  end
endmodule : charger_power_mode_controller_tb
